// >>> verilog/spi_master_slave_port.sv
// Purpose: Serial port core with register port, master and slave modes.
// Assumes: Clock idles low, data sampled on rising, shifted on falling.
// Notes: Slave clock must stay well below clk/6 for edge detection.
`timescale 1ns/1ps
module spi_master_slave_port
	import spi_pkg::*;
(
	// System
	input  wire logic  clk,
	input  wire logic  rstn,
	input  wire logic  idle_mode,
	// Register port
	input  wire addr_t addr,
	input  wire word_t wdata,
	input  wire logic  wr,
	input  wire logic  rd,
	output word_t      rdata,
	// Link pins
	input  wire logic  shift_clock_i,
	output logic       shift_clock_o,
	output logic       shift_clock_oe,
	input  wire logic  serial_data_in,
	output logic       serial_data_out,
	output logic       serial_data_out_oe,
	input  wire logic  slave_select_n,
	// Interrupt
	output logic       irq
);
	link_if lk ();

	link_sampler u_sampler (
		.clk            (clk),
		.rstn           (rstn),
		.shift_clock_i  (shift_clock_i),
		.serial_data_in (serial_data_in),
		.slave_select_n (slave_select_n),
		.lk             (lk.drv)
	);

	shift_state_t state_r;
	logic         module_enable_r;
	logic         stop_in_idle_r;
	logic         master_mode_r;
	word_t        tx_holding_reg_r;
	word_t        rx_holding_reg_r;
	word_t        serial_shift_reg_r;
	logic         tx_buffer_full_r;
	logic         rx_buffer_full_r;
	logic         rx_overflow_flag_r;
	logic [3:0]   bit_cnt_r;
	logic [3:0]   div_cnt_r;
	logic         sample_r;
	irq_t         irq_stat_r;
	irq_t         irq_mask_r;
	word_t        rdata_r;
	logic         irq_r;
	logic         sck_o_r;
	logic         sck_oe_r;
	logic         sdo_oe_r;

	logic         halt;
	logic         run;
	logic         stat_wr;
	logic         ctrl_wr;
	logic         buf_wr;
	logic         buf_rd;
	logic         irqs_wr;
	logic         irqm_wr;
	logic         deselect;
	logic         start;
	logic         tx_load;
	logic         half_end;
	logic         rise_ev;
	logic         fall_ev;
	logic         word_done;
	logic         rx_store;
	logic         ovf_set;
	word_t        shift_nxt;
	word_t        stat_word;
	irq_t         irq_ev;

	// Register decode
	assign stat_wr = wr && addr == ADDR_STAT;
	assign ctrl_wr = wr && addr == ADDR_CTRL;
	assign buf_wr  = wr && addr == ADDR_BUF;
	assign buf_rd  = rd && addr == ADDR_BUF;
	assign irqs_wr = wr && addr == ADDR_IRQS;
	assign irqm_wr = wr && addr == ADDR_IRQM;

	// Engine control
	assign halt     = stop_in_idle_r & idle_mode; // [R05]
	assign run      = module_enable_r & ~halt; // [R04] [R05]
	assign deselect = ~master_mode_r & lk.ss_n; // [R02]
	assign start    = run && state_r == ST_IDLE &&
		(master_mode_r ? tx_buffer_full_r : ~lk.ss_n);
	assign tx_load  = start & tx_buffer_full_r;
	assign half_end = div_cnt_r == SCK_HALF_CYCLES - 4'h1;
	// Master times its own edges; slave follows the sampled pin
	assign rise_ev  = run && state_r == ST_LOW &&
		(master_mode_r ? half_end : lk.sck_rise); // [R03]
	assign fall_ev  = run && state_r == ST_HIGH &&
		(master_mode_r ? half_end : lk.sck_fall); // [R03]
	assign word_done = fall_ev && bit_cnt_r == LAST_BIT; // [R01]
	assign shift_nxt = {serial_shift_reg_r[14:0], sample_r}; // [R01]
	// A read in the same cycle frees the buffer for the new word
	assign rx_store  = word_done & (~rx_buffer_full_r | buf_rd); // [R06]
	assign ovf_set   = word_done & rx_buffer_full_r & ~buf_rd; // [R06]
	assign irq_ev    = {ovf_set, tx_load, rx_store};

	always_comb begin
		stat_word           = STAT_RESET;
		stat_word[EN_BIT]   = module_enable_r;
		stat_word[SIDL_BIT] = stop_in_idle_r;
		stat_word[OVF_BIT]  = rx_overflow_flag_r;
		stat_word[TBF_BIT]  = tx_buffer_full_r;
		stat_word[RBF_BIT]  = rx_buffer_full_r;
	end

	// Shift engine state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
		end else if (!module_enable_r || (deselect && state_r != ST_IDLE)) begin
			state_r <= ST_IDLE; // [R04]
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start) begin
						state_r <= ST_LOW;
					end
				end
				ST_LOW: begin
					if (rise_ev) begin
						state_r <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (word_done) begin
						state_r <= ST_IDLE;
					end else if (fall_ev) begin
						state_r <= ST_LOW;
					end
				end
			endcase
		end
	end

	// Master half-period divider, frozen while halted
	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_cnt_r <= 4'h0;
		end else if (!module_enable_r || state_r == ST_IDLE) begin
			div_cnt_r <= 4'h0;
		end else if (run) begin
			div_cnt_r <= half_end ? 4'h0 : div_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			bit_cnt_r <= 4'h0;
		end else if (state_r == ST_IDLE) begin
			bit_cnt_r <= 4'h0;
		end else if (fall_ev) begin
			bit_cnt_r <= bit_cnt_r + 4'h1; // [R01]
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sample_r <= 1'b0;
		end else if (rise_ev) begin
			sample_r <= lk.sdi; // [R02]
		end
	end

	// Slave with nothing queued answers with zeros
	always_ff @(posedge clk) begin
		if (!rstn) begin
			serial_shift_reg_r <= WORD_ZERO;
		end else if (start) begin
			serial_shift_reg_r <= tx_buffer_full_r ? tx_holding_reg_r : WORD_ZERO; // [R01]
		end else if (fall_ev) begin
			serial_shift_reg_r <= shift_nxt; // [R01]
		end
	end

	// Transmit holding; a write while full replaces the queued word
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_holding_reg_r <= WORD_ZERO;
		end else if (buf_wr) begin
			tx_holding_reg_r <= wdata; // [R01]
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_buffer_full_r <= 1'b0;
		end else if (buf_wr) begin
			tx_buffer_full_r <= 1'b1; // [R07]
		end else if (tx_load) begin
			tx_buffer_full_r <= 1'b0; // [R07]
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_holding_reg_r <= WORD_ZERO;
		end else if (rx_store) begin
			rx_holding_reg_r <= shift_nxt; // [R08]
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_buffer_full_r <= 1'b0;
		end else if (rx_store) begin
			rx_buffer_full_r <= 1'b1; // [R08]
		end else if (buf_rd) begin
			rx_buffer_full_r <= 1'b0; // [R08]
		end
	end

	// Set wins over a simultaneous clearing write
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_overflow_flag_r <= 1'b0;
		end else if (ovf_set) begin
			rx_overflow_flag_r <= 1'b1; // [R06]
		end else if (stat_wr && !wdata[OVF_BIT]) begin
			rx_overflow_flag_r <= 1'b0; // [R09]
		end
	end

	// Control bits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			module_enable_r <= 1'b0;
			stop_in_idle_r  <= 1'b0;
		end else if (stat_wr) begin
			module_enable_r <= wdata[EN_BIT]; // [R04]
			stop_in_idle_r  <= wdata[SIDL_BIT]; // [R05]
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			master_mode_r <= 1'b0;
		end else if (ctrl_wr) begin
			master_mode_r <= wdata[MASTER_BIT];
		end
	end

	// Interrupt status, write one to clear, events win
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_stat_r <= IRQ_RESET;
		end else begin
			irq_stat_r <= (irq_stat_r & ~(irqs_wr ? wdata[2:0] : IRQ_RESET)) | irq_ev;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_mask_r <= IRQ_RESET;
		end else if (irqm_wr) begin
			irq_mask_r <= wdata[2:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rstn || !rd) begin
			rdata_r <= WORD_ZERO;
		end else begin
			unique case (addr)
				ADDR_STAT: rdata_r <= stat_word;
				ADDR_CTRL: rdata_r <= {15'h0000, master_mode_r};
				ADDR_BUF:  rdata_r <= rx_holding_reg_r; // [R01]
				ADDR_IRQS: rdata_r <= {13'h0000, irq_stat_r};
				ADDR_IRQM: rdata_r <= {13'h0000, irq_mask_r};
				default:   rdata_r <= WORD_ZERO;
			endcase
		end
	end

	// Pin drivers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sck_o_r <= 1'b0;
		end else if (rise_ev && master_mode_r) begin
			sck_o_r <= 1'b1; // [R03]
		end else if (fall_ev || state_r == ST_IDLE || !module_enable_r) begin
			sck_o_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sck_oe_r <= 1'b0;
			sdo_oe_r <= 1'b0;
		end else begin
			sck_oe_r <= module_enable_r & master_mode_r; // [R03] [R04]
			sdo_oe_r <= module_enable_r & (master_mode_r | ~lk.ss_n); // [R02] [R04]
		end
	end

	assign shift_clock_o      = sck_o_r;
	assign shift_clock_oe     = sck_oe_r;
	assign serial_data_out    = serial_shift_reg_r[15];
	assign serial_data_out_oe = sdo_oe_r;
	assign rdata              = rdata_r;
	assign irq                = irq_r;

	sequence s_buf_write;
		wr && addr == ADDR_BUF;
	endsequence
	sequence s_word_free;
		word_done && !rx_buffer_full_r;
	endsequence
	sequence s_word_lost;
		word_done && rx_buffer_full_r && !buf_rd;
	endsequence
	a_load_word: assert property (@(posedge clk) disable iff (!rstn) // [R01]
		tx_load |=> serial_shift_reg_r == $past(tx_holding_reg_r))
		else $error("shift register not loaded from holding");
	// Enables are registered, so judge the cycle in which they were computed
	a_slave_quiet: assert property (@(posedge clk) disable iff (!rstn) // [R02]
		module_enable_r && !master_mode_r && lk.ss_n |=> !serial_data_out_oe)
		else $error("data out driven while deselected");
	a_clock_dir: assert property (@(posedge clk) disable iff (!rstn) // [R03]
		##1 shift_clock_oe == $past(module_enable_r && master_mode_r))
		else $error("shift clock direction wrong");
	a_disable_off: assert property (@(posedge clk) disable iff (!rstn) // [R04]
		!module_enable_r |=> state_r == ST_IDLE && !shift_clock_oe && !serial_data_out_oe)
		else $error("module active while disabled");
	a_idle_freeze: assert property (@(posedge clk) disable iff (!rstn) // [R05]
		halt && module_enable_r && state_r != ST_IDLE && !deselect
		|=> $stable(serial_shift_reg_r) && $stable(bit_cnt_r) && $stable(state_r))
		else $error("shifting during idle halt");
	a_overflow_drop: assert property (@(posedge clk) disable iff (!rstn) // [R06]
		s_word_lost |=> rx_overflow_flag_r && $stable(rx_holding_reg_r))
		else $error("overflow not flagged or word kept");
	a_txfull_flow: assert property (@(posedge clk) disable iff (!rstn) // [R07]
		s_buf_write ##1 (tx_load && !buf_wr) |=> !tx_buffer_full_r)
		else $error("transmit full not cleared on load");
	a_txfull_set: assert property (@(posedge clk) disable iff (!rstn) // [R07]
		s_buf_write |=> tx_buffer_full_r && tx_holding_reg_r == $past(wdata))
		else $error("transmit full not set on write");
	a_rx_store: assert property (@(posedge clk) disable iff (!rstn) // [R08]
		s_word_free |=> rx_buffer_full_r ##0 rx_holding_reg_r == $past(shift_nxt))
		else $error("received word not stored");
	a_rx_read: assert property (@(posedge clk) disable iff (!rstn) // [R08]
		buf_rd && !word_done |=> !rx_buffer_full_r)
		else $error("receive full not cleared on read");
	a_ovf_keep: assert property (@(posedge clk) disable iff (!rstn) // [R09]
		rx_overflow_flag_r && !(stat_wr && !wdata[OVF_BIT]) |=> rx_overflow_flag_r)
		else $error("overflow cleared without zero write");
endmodule : spi_master_slave_port

// >>> verilog/spi_pkg.sv
// Purpose: Shared constants and types for the serial port block.
// Assumes: 16-bit register port, byte offsets on word boundaries.
// Notes:
// Function
// [R01] 16-bit shift register, separate software buffer
// [R02] Four pins: data in, out, clock, select
// [R03] Master drives shift clock; slave receives it
// [R04] Enable bit claims pins; clear switches off
// [R05] Stop-in-idle bit halts module during idle
// [R06] Overflow: new word discarded, flag set
// [R07] Transmit full set on write, cleared on load
// [R08] Receive full set on store, cleared on read
// [R09] Overflow cleared only by writing zero
package spi_pkg;
	typedef logic [15:0] word_t;
	typedef logic [4:0]  addr_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOW  = 3'b010,
		ST_HIGH = 3'b100
	} shift_state_t;

	localparam addr_t ADDR_STAT = 5'h00;
	localparam addr_t ADDR_CTRL = 5'h04;
	localparam addr_t ADDR_BUF  = 5'h08;
	localparam addr_t ADDR_IRQS = 5'h0C;
	localparam addr_t ADDR_IRQM = 5'h10;

	localparam int EN_BIT     = 15;
	localparam int SIDL_BIT   = 13;
	localparam int OVF_BIT    = 6;
	localparam int TBF_BIT    = 1;
	localparam int RBF_BIT    = 0;
	localparam int MASTER_BIT = 0;

	localparam int IRQ_RX  = 0;
	localparam int IRQ_TX  = 1;
	localparam int IRQ_OVF = 2;
	typedef logic [2:0] irq_t;

	localparam word_t STAT_RESET = 16'h0000;
	localparam word_t WORD_ZERO  = 16'h0000;
	localparam irq_t  IRQ_RESET  = 3'h0;

	localparam logic [3:0] LAST_BIT        = 4'hF;
	localparam logic [3:0] SCK_HALF_CYCLES = 4'h4;
endpackage : spi_pkg

// >>> verilog/link_if.sv
// Purpose: Sampled link signals passed from the pin sampler to the core.
// Assumes: All members are in the clk domain.
// Notes: Edges are one-cycle pulses.
`timescale 1ns/1ps
interface link_if;
	logic sck_rise;
	logic sck_fall;
	logic sdi;
	logic ss_n;

	modport drv  (output sck_rise, output sck_fall, output sdi, output ss_n);
	modport core (input sck_rise, input sck_fall, input sdi, input ss_n);
endinterface : link_if

// >>> verilog/link_sampler.sv
// Purpose: Synchronise link pins to clk and find shift clock edges.
// Assumes: Pins are asynchronous to clk.
// Notes: Edges lag the pin by one to two cycles.
`timescale 1ns/1ps
module link_sampler (
	// System
	input  wire logic clk,
	input  wire logic rstn,
	// Pins
	input  wire logic shift_clock_i,
	input  wire logic serial_data_in,
	input  wire logic slave_select_n,
	// Core side
	link_if.drv       lk
);
	logic sck_s1_r;
	logic sck_s2_r;
	logic sck_s3_r;
	logic sdi_s1_r;
	logic sdi_s2_r;
	logic ss_s1_r;
	logic ss_s2_r;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sck_s1_r <= 1'b0;
			sck_s2_r <= 1'b0;
			sck_s3_r <= 1'b0;
			sdi_s1_r <= 1'b0;
			sdi_s2_r <= 1'b0;
			ss_s1_r  <= 1'b1;
			ss_s2_r  <= 1'b1;
		end else begin
			sck_s1_r <= shift_clock_i;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			sdi_s1_r <= serial_data_in;
			sdi_s2_r <= sdi_s1_r;
			ss_s1_r  <= slave_select_n;
			ss_s2_r  <= ss_s1_r;
		end
	end

	// Edge detect looks only past the second stage
	assign lk.sck_rise = sck_s2_r & ~sck_s3_r;
	assign lk.sck_fall = ~sck_s2_r & sck_s3_r;
	assign lk.sdi      = sdi_s2_r;
	assign lk.ss_n     = ss_s2_r;
endmodule : link_sampler

// >>> sim/spi_far_end.sv
// Purpose: Far-end serial peer, master or slave of the block.
// Assumes: Clock idles low, sample on rising, shift on falling, MSB first.
// Notes: Stale data bits are inverted so they never pass for data.
`timescale 1ns/1ps
module spi_far_end
	import spi_pkg::*;
(
	// From block
	input  wire logic shift_clock_o,
	input  wire logic serial_data_out,
	// To block
	output logic      shift_clock,
	output logic      serial_data_in,
	output logic      slave_select_n
);
	word_t sh_r;
	word_t rx_word;
	logic  own_r;
	wire logic sck = own_r ? shift_clock : shift_clock_o;
	initial begin
		shift_clock = 1'b0;
		slave_select_n = 1'b1;
		own_r = 1'b0;
		sh_r = 16'h5555;
		rx_word = 16'h0000;
	end
	assign serial_data_in = sh_r[15];
	always @(posedge sck) begin
		rx_word <= {rx_word[14:0], serial_data_out};
	end
	always @(negedge sck) begin
		sh_r <= {sh_r[14:0], ~sh_r[15]};
	end
	task automatic preload(input word_t w);
		sh_r = w;
	endtask : preload
	task automatic frame(input word_t w);
		own_r = 1'b1;
		sh_r = w;
		slave_select_n = 1'b0;
		#200;
		repeat (16) begin
			shift_clock = 1'b1;
			#80;
			shift_clock = 1'b0;
			#80;
		end
		#100;
		slave_select_n = 1'b1;
		own_r = 1'b0;
	endtask : frame
endmodule : spi_far_end

// >>> sim/tb_top.sv
// Purpose: Register-level test of the serial port, master and slave.
// Assumes: Far-end model runs the link at 160 ns per bit.
// Notes: Waits poll interrupt status, so a hang ends as a mismatch.
`timescale 1ns/1ps
module tb_top
	import spi_pkg::*;
;
	logic  clk, rstn, idle_mode, wr, rd;
	addr_t addr;
	word_t wdata;
	word_t rdata;
	logic  sck_o, sck_oe, sck_pin, sdi, sdo, sdo_oe, ss_n, irq;
	int    err_total;
	int    check_count;

	spi_master_slave_port u_dut (
		.clk(clk), .rstn(rstn), .idle_mode(idle_mode),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.shift_clock_i(sck_pin), .shift_clock_o(sck_o), .shift_clock_oe(sck_oe),
		.serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
		.slave_select_n(ss_n), .irq(irq)
	);
	// A released data line shows the inverse, so stale bits never pass for data
	spi_far_end u_far (
		.shift_clock_o(sck_o), .serial_data_out(sdo_oe ? sdo : ~sdo),
		.shift_clock(sck_pin), .serial_data_in(sdi), .slave_select_n(ss_n)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string nm, input word_t e, input word_t g);
		check_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk

	task automatic wr_reg(input addr_t a, input word_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input addr_t a, output word_t d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic rd_chk(input addr_t a, input word_t e, input string nm);
		word_t d;
		rd_reg(a, d);
		chk(nm, e, d);
	endtask : rd_chk

	task automatic wait_ev(input word_t m);
		word_t d;
		int    n;
		for (n = 0; n < 400; n++) begin
			rd_reg(ADDR_IRQS, d);
			if ((d & m) != 16'h0000)
				break;
		end
		if (n == 400) begin
			$display("mismatch event wait expected %h seen %h", m, d);
			err_total++;
			end_sim();
		end
	endtask : wait_ev

	// Clearing events first keeps an old event from ending the wait early
	task automatic xfer(input word_t far_w, input word_t dut_w);
		wr_reg(ADDR_IRQS, 16'h0007);
		u_far.preload(far_w);
		wr_reg(ADDR_BUF, dut_w);
		wait_ev(16'h0005);
	endtask : xfer

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	initial begin
		rstn = 1'b0;
		idle_mode = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = ADDR_STAT;
		wdata = WORD_ZERO;
		err_total = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(ADDR_STAT, 16'h0000, "status at reset");
		rd_chk(ADDR_CTRL, 16'h0000, "control at reset");
		rd_chk(5'h1C, 16'h0000, "unmapped read");
		chk("clock drive at reset", 16'h0000, {15'h0000, sck_oe});
		$display("test reset done");
		@(posedge clk);
		idle_mode <= 1'b1;
		wr_reg(ADDR_CTRL, 16'h0001);
		wr_reg(ADDR_IRQM, 16'h0001);
		wr_reg(ADDR_STAT, 16'h8000);
		xfer(16'h3C5A, 16'hA5C3);
		chk("irq on receive", 16'h0001, {15'h0000, irq});
		chk("clock drive in master", 16'h0001, {15'h0000, sck_oe});
		chk("far end word", 16'hA5C3, u_far.rx_word);
		rd_chk(ADDR_STAT, 16'h8001, "receive full");
		rd_chk(ADDR_BUF, 16'h3C5A, "received word");
		rd_chk(ADDR_STAT, 16'h8000, "receive full cleared");
		wr_reg(ADDR_IRQS, 16'h0007);
		rd_chk(ADDR_IRQS, 16'h0000, "irq status cleared");
		chk("irq after clear", 16'h0000, {15'h0000, irq});
		$display("test master done");
		xfer(16'h1111, 16'h0001);
		xfer(16'h2222, 16'h0002);
		rd_chk(ADDR_STAT, 16'h8041, "overflow set");
		rd_chk(ADDR_BUF, 16'h1111, "first word kept");
		wr_reg(ADDR_STAT, 16'h8043);
		rd_chk(ADDR_STAT, 16'h8040, "write ones to flags");
		wr_reg(ADDR_STAT, 16'h8000);
		rd_chk(ADDR_STAT, 16'h8000, "overflow cleared");
		$display("test overflow done");
		wr_reg(ADDR_STAT, 16'hA000);
		wr_reg(ADDR_IRQS, 16'h0007);
		u_far.preload(16'h4B4B);
		wr_reg(ADDR_BUF, 16'h7E81);
		// Longer than two whole words, so a running engine would have finished
		repeat (300) @(posedge clk);
		rd_chk(ADDR_STAT, 16'hA002, "halted in idle");
		@(posedge clk);
		idle_mode <= 1'b0;
		// Idle again mid-word: the engine must freeze, not finish the word
		repeat (40) @(posedge clk);
		idle_mode <= 1'b1;
		repeat (300) @(posedge clk);
		rd_chk(ADDR_IRQS, 16'h0002, "frozen mid word");
		@(posedge clk);
		idle_mode <= 1'b0;
		wait_ev(16'h0005);
		rd_chk(ADDR_BUF, 16'h4B4B, "word after idle");
		chk("far end after idle", 16'h7E81, u_far.rx_word);
		$display("test idle done");
		wr_reg(ADDR_CTRL, 16'h0000);
		wr_reg(ADDR_STAT, 16'h8000);
		wr_reg(ADDR_IRQS, 16'h0007);
		wr_reg(ADDR_BUF, 16'h6699);
		rd_chk(ADDR_STAT, 16'h8002, "queued in slave");
		u_far.frame(16'hC33C);
		wait_ev(16'h0005);
		rd_chk(ADDR_BUF, 16'hC33C, "slave received");
		chk("slave sent", 16'h6699, u_far.rx_word);
		chk("no clock drive in slave", 16'h0000, {15'h0000, sck_oe});
		wr_reg(ADDR_STAT, 16'h0000);
		rd_chk(ADDR_STAT, 16'h0000, "disabled status");
		chk("data drive off", 16'h0000, {15'h0000, sdo_oe});
		$display("test slave done");
		end_sim();
	end
endmodule : tb_top
